//--- shared/tmspc_pkg.sv
// Purpose: Shared constants for the touch matrix scan and power control block
// Assumes: 100 MHz clock, 32-bit AHB-Lite register access
// Notes:   Byte offsets, field positions, reset values and timing figures

package tmspc_pkg;

   // Register byte offsets
   localparam logic [7:0] TMSPC_GLOBAL_CFG_OFS = 8'h00;
   localparam logic [7:0] TMSPC_AWAKE_OFS      = 8'h04;
   localparam logic [7:0] TMSPC_DRIFT_OFS      = 8'h08;
   localparam logic [7:0] TMSPC_KEY_EN_OFS     = 8'h0c;
   localparam logic [7:0] TMSPC_STATUS_OFS     = 8'h10;
   localparam logic [7:0] TMSPC_KEY_STATE_OFS  = 8'h14;
   localparam logic [7:0] TMSPC_MODE_OFS       = 8'h18;
   localparam logic [7:0] TMSPC_KEY_CFG_OFS    = 8'h40;

   // Per-key configuration byte fields
   localparam int TMSPC_ROUSE_BIT   = 3;
   localparam int TMSPC_BURST_LO    = 4;
   localparam int TMSPC_SUPPR_BIT   = 6;
   localparam int TMSPC_SCOPE_BIT   = 7;
   // Global configuration byte fields
   localparam int TMSPC_SLEEP_HI    = 2;
   localparam int TMSPC_LOCK_BIT    = 6;
   // Status register fields
   localparam int TMSPC_ST_FAST     = 0;
   localparam int TMSPC_ST_SLEEP    = 1;
   localparam int TMSPC_ST_FREEZE   = 2;
   localparam int TMSPC_ST_CHANGE   = 3;

   // Reset values
   localparam logic [7:0] TMSPC_KEY_CFG_RST    = 8'h28;
   localparam logic [7:0] TMSPC_GLOBAL_CFG_RST = 8'h03;
   localparam logic [7:0] TMSPC_AWAKE_RST      = 8'h19;
   localparam logic [7:0] TMSPC_DRIFT_RST      = 8'h0a;

   // Timing
   localparam int TMSPC_CLK_PERIOD_NS = 10;
   localparam int TMSPC_MS_NS         = 1000000;
   localparam int TMSPC_MS_CYCLES     = TMSPC_MS_NS / TMSPC_CLK_PERIOD_NS;
   localparam logic [15:0] TMSPC_SYNC_WAIT_MS   = 16'h0064;
   localparam logic [15:0] TMSPC_UNIT_MS        = 16'h0064;
   localparam logic [7:0]  TMSPC_SHIFT_AWAKE    = 8'h19;
   localparam logic [7:0]  TMSPC_PULSES_STEP    = 8'h10;

   // Sleep interval in ms per three-bit index
   function automatic logic [15:0] tmspc_sleep_ms(input logic [2:0] idx);
      logic [15:0] r;
      r = 16'h0010;
      unique case (idx)
         3'h0: r = 16'h0010;
         3'h1: r = 16'h0020;
         3'h2: r = 16'h0040;
         3'h3: r = 16'h007d;
         3'h4: r = 16'h00fa;
         3'h5: r = 16'h01f4;
         3'h6: r = 16'h03e8;
         3'h7: r = 16'h07d0;
      endcase
      return r;
   endfunction : tmspc_sleep_ms

   typedef enum logic [1:0] {TMSPC_SLEEP, TMSPC_WAIT_SYNC, TMSPC_BURST} tmspc_state_t;

endpackage : tmspc_pkg

//--- tb/tb_tmspc_core.sv
// Purpose: Self-checking bench for the scan and power control block
// Assumes: One ms scaled to 10 cycles
// Notes:   Register model in an associative array
`timescale 1ns/1ps
module tb_tmspc_core;
   import tmspc_pkg::*;
   localparam int MSC = 10;
   logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, line_run = 1'b0;
   logic         hready, hreadyout, hresp, drive_pulse, receive_enable, scope_marker;
   logic         change_n, fast_mode, sleeping, drift_freeze, line_pin, sc;
   logic [1:0]   htrans = 2'h0;
   logic [31:0]  haddr = '0, hwdata = '0, hrdata, r;
   logic [23:0]  key_touch = '0, key_detect;
   logic [287:0] key_deviation = '0;
   logic [4:0]   scan_key;
   int           n_mismatch = 0, num_checks = 0, cyc = 0, k, n, s1, s2, d0, e;
   int           mdl[int];
   int           slp[5] = '{16, 32, 64, 125, 250};

   assign hready = hreadyout;
   always #5 hclk = ~hclk;

   tmspc_core #(.MS_CYCLES(MSC)) tmspc_core_i (
      .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .key_touch(key_touch),
      .key_deviation(key_deviation), .line_sync_pin(line_pin), .drive_pulse(drive_pulse),
      .receive_enable(receive_enable), .scan_key(scan_key), .scope_marker(scope_marker),
      .change_n(change_n), .fast_mode(fast_mode), .sleeping(sleeping),
      .drift_freeze(drift_freeze), .key_detect(key_detect));

   tmspc_line_src tmspc_line_src_i (.hclk(hclk), .run(line_run), .line_out(line_pin));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Hang guard, well above the planned run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int c);
      repeat (c) @(posedge hclk);
   endtask : tick

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, r);
      if (mdl.exists(a)) mdl[a] = d;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 0, r);
      chk(r, mdl.exists(a) ? mdl[a] : 0);
   endtask : rd

   // Waits out any burst in flight, then measures the next one
   task automatic burst(output int key, output int cnt, output logic scp, output int st);
      cnt = 0;
      while (receive_enable === 1'b1) @(posedge hclk);
      while (receive_enable !== 1'b1) @(posedge hclk);
      st = cyc;
      key = scan_key;
      scp = scope_marker;
      while (receive_enable === 1'b1) begin
         cnt += drive_pulse;
         @(posedge hclk);
      end
   endtask : burst

   initial begin
      r = $urandom(32'h1915);
      mdl = '{0: 3, 4: 25, 8: 10, 12: 32'hffffff, 24: 0};
      for (k = 0; k < 24; k++) mdl[64 + 4 * k] = 8'h28;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (k = 0; k < 24; k++) rd(8'(64 + 4 * k));
      rd(8'h00);
      rd(8'h04);
      rd(8'h08);
      rd(8'h0c);
      wr(8'h30, $urandom);
      rd(8'h30);
      for (k = 0; k < 24; k++) begin
         wr(8'(64 + 4 * k), $urandom & 32'hf8);
         rd(8'(64 + 4 * k));
      end
      $display("test registers done");
      wr(8'h00, 0);
      wr(8'h0c, 32'h84);
      for (e = 0; e < 4; e++) begin
         wr(8'h48, 8'h08 | e << 4);
         wr(8'h5c, 8'h88 | (3 - e) << 4);
         while (sleeping !== 1'b1) @(posedge hclk);
         burst(k, n, sc, s1);
         chk(k, 2);
         chk(n, 16 * (e + 1));
         chk(sc, 0);
         burst(k, n, sc, s1);
         chk(k, 7);
         chk(n, 16 * (4 - e));
         chk(sc, 1);
      end
      $display("test bursts done");
      wr(8'h0c, 32'h04);
      wr(8'h48, 32'h08);
      for (e = 0; e < 7; e++) begin
         wr(8'h00, e < 5 ? e : 32'h40);
         line_run <= (e == 6);
         while (sleeping !== 1'b1) @(posedge hclk);
         burst(k, n, sc, s1);
         burst(k, n, sc, s2);
         s2 -= s1;
         if (e < 5) chk(s2 >= slp[e] * MSC && s2 < slp[e] * MSC + 80, 1);
         else if (e == 5) chk(s2 >= 100 * MSC && s2 < 100 * MSC + 100, 1);
         else chk(s2 >= 32 && s2 < 100 * MSC, 1);
      end
      $display("test sleep and line lock done");
      line_run <= 1'b0;
      wr(8'h00, 0);
      wr(8'h04, 1);
      wr(8'h0c, 32'h0c);
      wr(8'h48, 32'h28);
      wr(8'h4c, 32'h20);
      key_touch[3] <= 1'b1;
      tick(20);
      chk(fast_mode, 0);
      key_touch[2] <= 1'b1;
      tick(3);
      chk(fast_mode, 1);
      chk(change_n, 0);
      tick(600);
      key_touch[3] <= 1'b0;
      tick(700);
      chk(fast_mode, 1);
      chk(sleeping, 0);
      tick(1000);
      chk(fast_mode, 0);
      bus(1'b0, 8'h10, 0, r);
      chk(r[3], 1);
      bus(1'b0, 8'h10, 0, r);
      chk(r[3], 0);
      $display("test fast mode done");
      wr(8'h18, 1);
      key_touch[3] <= 1'b1;
      tick(3);
      chk(fast_mode, 1);
      chk(change_n, 1);
      tick(20000);
      chk(fast_mode, 1);
      tick(6000);
      chk(fast_mode, 0);
      wr(8'h18, 0);
      $display("test shift mode done");
      wr(8'h08, 1);
      wr(8'h0c, 32'h07);
      wr(8'h40, 32'h40);
      wr(8'h44, 32'h70);
      wr(8'h48, 32'h00);
      key_touch <= 24'h0;
      tick(1500);
      d0 = -20 - int'($urandom % 40);
      key_deviation[0 +: 36] <= {12'(-200), 12'(d0 + 5), 12'(d0)};
      key_touch <= 24'h7;
      tick(400);
      chk(key_detect[2:0], 3'h5);
      chk(drift_freeze, 1);
      key_deviation[12 +: 12] <= 12'(d0 - 5);
      tick(400);
      chk(key_detect[2:0], 3'h6);
      key_touch <= 24'h0;
      tick(1500);
      chk(drift_freeze, 0);
      wr(8'h08, 0);
      key_touch <= 24'h4;
      tick(400);
      chk(key_detect[2:0], 3'h4);
      chk(drift_freeze, 0);
      $display("test suppression and drift done");
      give_verdict();
   end
endmodule : tb_tmspc_core

bind tmspc_core tmspc_core_props #(.NKEYS(NKEYS)) tmspc_core_props_i (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .drive_pulse(drive_pulse), .receive_enable(receive_enable), .scan_key(scan_key),
   .scope_marker(scope_marker), .change_n(change_n), .fast_mode(fast_mode),
   .sleeping(sleeping));

//--- tb/tmspc_core_props.sv
// Purpose: Port-level checks for the scan and power control block
// Assumes: Bound to the core, one clock domain
// Notes:   A pulse counter gives the burst length check
`timescale 1ns/1ps
module tmspc_core_props #(
   parameter int NKEYS = 24
) (
   // Clock and reset
   input wire logic                     hclk,
   input wire logic                     hresetn,
   // Bus answer
   input wire logic                     hreadyout,
   input wire logic                     hresp,
   // Scan pins
   input wire logic                     drive_pulse,
   input wire logic                     receive_enable,
   input wire logic [$clog2(NKEYS)-1:0] scan_key,
   input wire logic                     scope_marker,
   input wire logic                     change_n,
   // Power state
   input wire logic                     fast_mode,
   input wire logic                     sleeping
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Counts pulses while receive is open, cleared between bursts
   logic [7:0] npul;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         npul <= 8'h00;
      else if (!receive_enable)
         npul <= 8'h00;
      else
         npul <= npul + {7'h00, drive_pulse};
   end
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   burst_count_a: assert property ($fell(receive_enable) |-> npul inside {8'h10, 8'h20, 8'h30, 8'h40})
      else $error("burst pulse count wrong");
   drive_in_rx_a: assert property (drive_pulse |-> receive_enable)
      else $error("drive pulse outside burst");
   drive_gap_a: assert property (drive_pulse |=> !drive_pulse)
      else $error("drive pulse too long");
   rx_first_a: assert property ($rose(receive_enable) |-> drive_pulse)
      else $error("burst opened without pulse");
   scope_in_rx_a: assert property (scope_marker |-> receive_enable)
      else $error("scope marker outside burst");
   key_steady_a: assert property (receive_enable && $past(receive_enable) |-> $stable(scan_key))
      else $error("scan key moved in burst");
   change_fast_a: assert property ($fell(change_n) |-> fast_mode)
      else $error("change without fast mode");
   sleep_idle_a: assert property (sleeping |-> !receive_enable)
      else $error("burst while sleeping");
   fast_awake_a: assert property (fast_mode && $past(fast_mode) |-> !sleeping)
      else $error("sleep in fast mode");
endmodule : tmspc_core_props

//--- tb/tmspc_line_src.sv
// Purpose: Mains-derived logic source for the line lock input
// Assumes: Buffered logic level
// Notes:   Half period in cycles, scaled down for simulation
`timescale 1ns/1ps
module tmspc_line_src #(
   parameter int HALF = 150
) (
   // Clock and control
   input  wire logic hclk,
   input  wire logic run,
   // Level toward the sync pin
   output logic      line_out
);
   int cnt = 0;
   initial line_out = 1'b1;
   // Idle high when stopped, so no stray falling edge
   always @(posedge hclk) begin
      if (!run || cnt == HALF - 1) begin
         cnt <= 0;
         line_out <= run ? ~line_out : 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : tmspc_line_src

//--- verilog/tmspc_core.sv
// Purpose: Scan sequencing and power-state control for a capacitive key matrix
// Assumes: Detection states and signed deviations come from acquisition logic on hclk
// Notes:   Zero-wait AHB-Lite slave; all timers run off a 1 ms tick

`timescale 1ns/1ps

module tmspc_core
   import tmspc_pkg::*;
#(
   parameter int NKEYS     = 24,
   parameter int DEV_W     = 12,
   parameter int MS_CYCLES = tmspc_pkg::TMSPC_MS_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   clk_en,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Acquisition side
   input  wire logic [NKEYS-1:0]       key_touch,
   input  wire logic [NKEYS*DEV_W-1:0] key_deviation,
   // Pins
   input  wire logic                   line_sync_pin,
   output logic                        drive_pulse,
   output logic                        receive_enable,
   output logic [$clog2(NKEYS)-1:0]    scan_key,
   output logic                        scope_marker,
   output logic                        change_n,
   // Power and drift state
   output logic                        fast_mode,
   output logic                        sleeping,
   output logic                        drift_freeze,
   output logic [NKEYS-1:0]            key_detect
);
   import tmspc_pkg::*;

   localparam int KIW = $clog2(NKEYS);
   localparam int MSW = $clog2(MS_CYCLES + 1);

   // Registers
   logic [7:0]       key_cfg [NKEYS];
   logic [7:0]       global_cfg;
   logic [7:0]       awake_time;
   logic [7:0]       drift_freeze_time;
   logic [NKEYS-1:0] slow_confirm_nonzero;
   logic             shift_mode;
   logic             change_flag;

   // AHB address phase capture
   logic             wr_pend;
   logic [7:0]       wr_addr;

   wire  logic       bus_take   = hsel & htrans[1] & hready;
   wire  logic [7:0] a_ofs      = haddr[7:0];
   wire  logic       a_in_keys  = (a_ofs >= TMSPC_KEY_CFG_OFS) &&
                                  (a_ofs < 8'(TMSPC_KEY_CFG_OFS + 4 * NKEYS));
   wire  logic [7:0] a_key      = (a_ofs - TMSPC_KEY_CFG_OFS) >> 2;
   wire  logic       w_in_keys  = (wr_addr >= TMSPC_KEY_CFG_OFS) &&
                                  (wr_addr < 8'(TMSPC_KEY_CFG_OFS + 4 * NKEYS));
   wire  logic [7:0] w_key      = (wr_addr - TMSPC_KEY_CFG_OFS) >> 2;
   wire  logic       wr_now     = wr_pend & clk_en;
   wire  logic       status_rd  = bus_take & ~hwrite & (a_ofs == TMSPC_STATUS_OFS);

   logic [31:0]      read_mux;
   logic [NKEYS-1:0] det_prev;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_comb begin
      read_mux = 32'h0000_0000;
      if (a_in_keys) begin
         read_mux = {24'h00_0000, key_cfg[a_key[KIW-1:0]]};
      end else begin
         unique case (a_ofs)
            TMSPC_GLOBAL_CFG_OFS: read_mux = {24'h00_0000, global_cfg};
            TMSPC_AWAKE_OFS:      read_mux = {24'h00_0000, awake_time};
            TMSPC_DRIFT_OFS:      read_mux = {24'h00_0000, drift_freeze_time};
            TMSPC_KEY_EN_OFS:     read_mux = 32'(slow_confirm_nonzero);
            TMSPC_STATUS_OFS:     read_mux = {28'h000_0000, change_flag, drift_freeze,
                                              sleeping, fast_mode};
            TMSPC_KEY_STATE_OFS:  read_mux = 32'(det_prev);
            TMSPC_MODE_OFS:       read_mux = {31'h0000_0000, shift_mode};
            default:              read_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         wr_pend <= bus_take & hwrite;
         wr_addr <= a_ofs;
         if (bus_take & ~hwrite) begin
            hrdata <= read_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int k = 0; k < NKEYS; k++) begin
            key_cfg[k] <= TMSPC_KEY_CFG_RST;
         end
      end else if (wr_now && w_in_keys) begin
         key_cfg[w_key[KIW-1:0]] <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_cfg           <= TMSPC_GLOBAL_CFG_RST;
         awake_time           <= TMSPC_AWAKE_RST;
         drift_freeze_time    <= TMSPC_DRIFT_RST;
         slow_confirm_nonzero <= '1;
         shift_mode           <= 1'b0;
      end else if (wr_now) begin
         unique case (wr_addr)
            TMSPC_GLOBAL_CFG_OFS: global_cfg           <= hwdata[7:0];
            TMSPC_AWAKE_OFS:      awake_time           <= hwdata[7:0];
            TMSPC_DRIFT_OFS:      drift_freeze_time    <= hwdata[7:0];
            TMSPC_KEY_EN_OFS:     slow_confirm_nonzero <= hwdata[NKEYS-1:0];
            TMSPC_MODE_OFS:       shift_mode           <= hwdata[0];
            default:              ;
         endcase
      end
   end

   logic [NKEYS-1:0] suppressed;
   genvar gi, gj;
   generate
      for (gi = 0; gi < NKEYS; gi++) begin : g_sup
         logic [NKEYS-1:0] beaten;
         for (gj = 0; gj < NKEYS; gj++) begin : g_cmp
            if (gi == gj) begin : g_self
               assign beaten[gj] = 1'b0;
            end else begin : g_other
               assign beaten[gj] = key_cfg[gj][TMSPC_SUPPR_BIT] &&
                  ($signed(key_deviation[gj*DEV_W +: DEV_W]) <
                   $signed(key_deviation[gi*DEV_W +: DEV_W]));
            end
         end
         assign suppressed[gi] = key_cfg[gi][TMSPC_SUPPR_BIT] & (|beaten);
      end
   endgenerate

   wire logic [NKEYS-1:0] det_now = key_touch & ~suppressed;
   wire logic [NKEYS-1:0] changed = det_now ^ det_prev;
   wire logic [NKEYS-1:0] new_det = det_now & ~det_prev;

   logic [NKEYS-1:0] rouse_mask;
   always_comb begin
      for (int k = 0; k < NKEYS; k++) begin
         rouse_mask[k] = key_cfg[k][TMSPC_ROUSE_BIT];
      end
   end

   // rouse mask, all keys in shift mode
   wire logic rouse_evt = |(changed & (shift_mode ? '1 : rouse_mask));
   wire logic any_change = |changed;

   // Millisecond tick; trades timer resolution for narrow counters
   logic [MSW-1:0] ms_div;
   wire  logic     ms_tick = (ms_div == MSW'(MS_CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_div <= '0;
      end else if (clk_en) begin
         ms_div <= ms_tick ? '0 : ms_div + MSW'(1);
      end
   end

   wire logic [15:0] hold_ms = 16'(shift_mode ? TMSPC_SHIFT_AWAKE : awake_time) * TMSPC_UNIT_MS;
   wire logic [15:0] freeze_ms = 16'(drift_freeze_time) * TMSPC_UNIT_MS;

   logic [15:0] awake_cnt;
   logic [15:0] freeze_cnt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det_prev    <= '0;
         fast_mode   <= 1'b0;
         awake_cnt   <= 16'h0000;
         freeze_cnt  <= 16'h0000;
         change_flag <= 1'b0;
      end else if (clk_en) begin
         det_prev <= det_now;
         if (rouse_evt || (fast_mode && any_change)) begin
            fast_mode <= 1'b1;
            awake_cnt <= hold_ms;
         end else if (fast_mode && ms_tick) begin
            if (awake_cnt <= 16'h0001) begin
               fast_mode <= 1'b0;
               awake_cnt <= 16'h0000;
            end else begin
               awake_cnt <= awake_cnt - 16'h0001;
            end
         end
         // change flag; set beats a read clear
         if (rouse_evt && !shift_mode) begin
            change_flag <= 1'b1;
         end else if (status_rd || shift_mode) begin
            change_flag <= 1'b0;
         end
         if (|new_det && drift_freeze_time != 8'h00) begin
            freeze_cnt <= freeze_ms;
         end else if (ms_tick && freeze_cnt != 16'h0000) begin
            freeze_cnt <= freeze_cnt - 16'h0001;
         end
      end
   end

   assign drift_freeze = (freeze_cnt != 16'h0000);
   assign change_n     = ~change_flag;
   assign key_detect   = det_prev;

   // Line sync pin, three stages; the first feeds only the second
   logic sync_q1;
   logic sync_q2;
   logic sync_q3;
   logic sync_level;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_q1    <= 1'b0;
         sync_q2    <= 1'b0;
         sync_q3    <= 1'b0;
         sync_level <= 1'b0;
      end else if (clk_en) begin
         sync_q1 <= line_sync_pin;
         sync_q2 <= sync_q1;
         sync_q3 <= sync_q2;
         if (sync_q2 == sync_q3) begin
            sync_level <= sync_q3;
         end
      end
   end
   wire logic sync_fall = sync_level & (sync_q2 == sync_q3) & ~sync_q3;

   // next enabled key at or above a start index
   function automatic logic [KIW:0] next_key(input logic [NKEYS-1:0] m,
                                             input logic [KIW:0] from);
      logic [KIW:0] r;
      r = '0;
      for (int i = NKEYS - 1; i >= 0; i--) begin
         if (m[i] && (i >= int'(from))) begin
            r = {1'b1, KIW'(i)};
         end
      end
      return r;
   endfunction : next_key

   // Scan sequencer
   tmspc_state_t state;
   logic [15:0]  sleep_cnt;
   logic [15:0]  sync_cnt;
   logic [7:0]   pulse_cnt;
   logic         pulse_phase;

   wire logic [KIW:0] first_key = next_key(slow_confirm_nonzero, '0);
   wire logic [KIW:0] after_key = next_key(slow_confirm_nonzero,
                                           (KIW+1)'(scan_key) + (KIW+1)'(1));
   wire logic [1:0]   cur_bl    = key_cfg[scan_key][TMSPC_BURST_LO +: 2];
   wire logic [7:0]   burst_len = ({6'h00, cur_bl} + 8'h01) * TMSPC_PULSES_STEP;
   wire logic         lock_en   = global_cfg[TMSPC_LOCK_BIT];
   wire logic         burst_end = pulse_phase && (pulse_cnt == burst_len - 8'h01);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state          <= TMSPC_SLEEP;
         sleep_cnt      <= 16'h0000;
         sync_cnt       <= 16'h0000;
         pulse_cnt      <= 8'h00;
         pulse_phase    <= 1'b0;
         scan_key       <= '0;
         drive_pulse    <= 1'b0;
         receive_enable <= 1'b0;
         scope_marker   <= 1'b0;
         sleeping       <= 1'b1;
      end else if (clk_en) begin
         if (ms_tick && sync_cnt != 16'h0000) begin
            sync_cnt <= sync_cnt - 16'h0001;
         end
         unique case (state)
            TMSPC_SLEEP: begin
               if (fast_mode || sleep_cnt == 16'h0000) begin
                  sleeping <= 1'b0;
                  // no wait when lock is off
                  state    <= lock_en ? TMSPC_WAIT_SYNC : TMSPC_BURST;
                  scan_key <= first_key[KIW-1:0];
               end else begin
                  sleeping <= 1'b1;
                  if (ms_tick) begin
                     sleep_cnt <= sleep_cnt - 16'h0001;
                  end
               end
            end
            TMSPC_WAIT_SYNC: begin
               if (sync_fall || sync_cnt == 16'h0000) begin
                  state <= TMSPC_BURST;
               end
            end
            TMSPC_BURST: begin
               if (!first_key[KIW]) begin
                  // No enabled keys; the cycle still paces itself
                  receive_enable <= 1'b0;
                  drive_pulse    <= 1'b0;
                  scope_marker   <= 1'b0;
                  pulse_cnt      <= 8'h00;
                  pulse_phase    <= 1'b0;
                  state     <= TMSPC_SLEEP;
                  sleeping  <= ~fast_mode;
                  sleep_cnt <= tmspc_sleep_ms(global_cfg[TMSPC_SLEEP_HI:0]);
                  sync_cnt  <= TMSPC_SYNC_WAIT_MS;
               end else begin
                  // one drive pulse per transfer, receive held open
                  receive_enable <= ~burst_end;
                  drive_pulse    <= ~pulse_phase;
                  scope_marker   <= key_cfg[scan_key][TMSPC_SCOPE_BIT] & ~burst_end;
                  pulse_phase    <= ~pulse_phase;
                  if (pulse_phase) begin
                     pulse_cnt <= pulse_cnt + 8'h01;
                  end
                  if (burst_end) begin
                     pulse_cnt   <= 8'h00;
                     pulse_phase <= 1'b0;
                     drive_pulse <= 1'b0;
                     if (after_key[KIW]) begin
                        scan_key <= after_key[KIW-1:0];
                     end else begin
                        state     <= TMSPC_SLEEP;
                        sleeping  <= ~fast_mode;
                        sleep_cnt <= tmspc_sleep_ms(global_cfg[TMSPC_SLEEP_HI:0]);
                        sync_cnt  <= TMSPC_SYNC_WAIT_MS;
                     end
                  end
               end
            end
            default: state <= TMSPC_SLEEP;
         endcase
      end
   end

endmodule : tmspc_core
